// *** src/swc_map.svh ***
// Register map, field widths, reset values and timing counts
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_VERSION     8'h00
`define SWC_ADDR_VERSION_ALT 8'hff
`define SWC_ADDR_FIRST_COL   8'h01
`define SWC_ADDR_FIRST_ROW   8'h02
`define SWC_ADDR_WIN_ROWS    8'h03
`define SWC_ADDR_WIN_COLS    8'h04
`define SWC_ADDR_ROW_BLANK   8'h05
`define SWC_ADDR_FRAME_BLANK 8'h06
`define SWC_W_FIRST_COL      10
`define SWC_W_FIRST_ROW      9
`define SWC_W_WIN_ROWS       9
`define SWC_W_WIN_COLS       10
`define SWC_W_ROW_BLANK      10
`define SWC_W_FRAME_BLANK    15
`define SWC_RST_FIRST_COL    10'h001
`define SWC_RST_FIRST_ROW    9'h004
`define SWC_RST_WIN_ROWS     9'h1e0
`define SWC_RST_WIN_COLS     10'h2f0
`define SWC_RST_ROW_BLANK    10'h05e
`define SWC_RST_FRAME_BLANK  15'h002d
`define SWC_DARK_ROWS_LEAD   4
`endif

// *** src/swc_pkg.sv ***
// Types shared by the shadowed window configuration bank
package swc_pkg;
    typedef logic [7:0]  swc_addr_t;
    typedef logic [15:0] swc_data_t;
endpackage : swc_pkg

// *** src/swc_shadow_regs.sv ***
// Double-buffered window and blanking configuration registers
//
// Overview of operation
// - Shadowed fields have pending and live copies; serial sees pending.
// - Live copies alone drive the sensor; update only at frame-start.
// - Frame-start is the first dark row, four rows before frame active.
// - Unassigned bit positions read fixed and ignore writes.
// - Window writes during readout leave the current frame untouched.
// - First column bits 9:0, shadowed, legal 1-752, reset 1.
// - First row bits 8:0, shadowed, legal 4-482, reset 4.
// - Window height bits 8:0, shadowed, legal 1-480, reset 1E0.
// - Window width bits 9:0, shadowed, legal 1-752, reset 2F0.
// - Row blanking bits 9:0, shadowed, reset 05E, host keeps 43-1023.
// - Frame blanking bits 14:0, shadowed, reset 002D, host keeps 4-3000.
`timescale 1ns/1ps
`include "swc_map.svh"

module swc_shadow_regs #(
    parameter swc_pkg::swc_data_t VERSION_ID = 16'h0a5a // Arbitrary value
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire swc_pkg::swc_addr_t   reg_addr,
    input  wire swc_pkg::swc_data_t   reg_wr_data,
    output swc_pkg::swc_data_t        reg_rd_data,
    output logic                      reg_rd_valid,
    input  wire logic                 first_dark_row,
    output logic [9:0]                live_first_col,
    output logic [8:0]                live_first_row,
    output logic [8:0]                live_win_rows,
    output logic [9:0]                live_win_cols,
    output logic [9:0]                live_row_blank,
    output logic [14:0]               live_frame_blank
);

    // Pending copies, written only from the serial side
    logic [9:0]  pend_first_col_r;
    logic [8:0]  pend_first_row_r;
    logic [8:0]  pend_win_rows_r;
    logic [9:0]  pend_win_cols_r;
    logic [9:0]  pend_row_blank_r;
    logic [14:0] pend_frame_blank_r;
    swc_pkg::swc_data_t rd_data_nxt;

    // Serial writes land in the pending copies; spare high bits dropped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_first_col_r   <= `SWC_RST_FIRST_COL;
            pend_first_row_r   <= `SWC_RST_FIRST_ROW;
            pend_win_rows_r    <= `SWC_RST_WIN_ROWS;
            pend_win_cols_r    <= `SWC_RST_WIN_COLS;
            pend_row_blank_r   <= `SWC_RST_ROW_BLANK;
            pend_frame_blank_r <= `SWC_RST_FRAME_BLANK;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `SWC_ADDR_FIRST_COL:   pend_first_col_r   <= reg_wr_data[9:0];
                `SWC_ADDR_FIRST_ROW:   pend_first_row_r   <= reg_wr_data[8:0];
                `SWC_ADDR_WIN_ROWS:    pend_win_rows_r    <= reg_wr_data[8:0];
                `SWC_ADDR_WIN_COLS:    pend_win_cols_r    <= reg_wr_data[9:0];
                `SWC_ADDR_ROW_BLANK:   pend_row_blank_r   <= reg_wr_data[9:0];
                `SWC_ADDR_FRAME_BLANK: pend_frame_blank_r <= reg_wr_data[14:0];
                default: ;
            endcase
        end
    end

    // All live copies load together on the frame-start pulse only, so a
    // frame never sees a mix of old and new window settings
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_first_col   <= `SWC_RST_FIRST_COL;
            live_first_row   <= `SWC_RST_FIRST_ROW;
            live_win_rows    <= `SWC_RST_WIN_ROWS;
            live_win_cols    <= `SWC_RST_WIN_COLS;
            live_row_blank   <= `SWC_RST_ROW_BLANK;
            live_frame_blank <= `SWC_RST_FRAME_BLANK;
        end else if (first_dark_row) begin
            live_first_col   <= pend_first_col_r;
            live_first_row   <= pend_first_row_r;
            live_win_rows    <= pend_win_rows_r;
            live_win_cols    <= pend_win_cols_r;
            live_row_blank   <= pend_row_blank_r;
            live_frame_blank <= pend_frame_blank_r;
        end
    end

    // Read mux sees pending only; unused bits read as zero
    always_comb begin
        rd_data_nxt = 16'h0000;
        case (reg_addr)
            `SWC_ADDR_VERSION,
            `SWC_ADDR_VERSION_ALT: rd_data_nxt = VERSION_ID;
            `SWC_ADDR_FIRST_COL:   rd_data_nxt = {6'h00, pend_first_col_r};
            `SWC_ADDR_FIRST_ROW:   rd_data_nxt = {7'h00, pend_first_row_r};
            `SWC_ADDR_WIN_ROWS:    rd_data_nxt = {7'h00, pend_win_rows_r};
            `SWC_ADDR_WIN_COLS:    rd_data_nxt = {6'h00, pend_win_cols_r};
            `SWC_ADDR_ROW_BLANK:   rd_data_nxt = {6'h00, pend_row_blank_r};
            `SWC_ADDR_FRAME_BLANK: rd_data_nxt = {1'h0, pend_frame_blank_r};
            default:               rd_data_nxt = 16'h0000;
        endcase
    end

    // Registered read answer one cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data  <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
                reg_rd_data <= rd_data_nxt;
        end
    end

    // Live copy holds between frame-start pulses despite writes
    a_live_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !first_dark_row |=> $stable(live_win_cols) && $stable(live_win_rows))
        else $error("live window changed outside frame-start");

    a_live_loads: assert property (@(posedge ref_clk) disable iff (!reset_n)
        first_dark_row |=> live_win_cols == $past(pend_win_cols_r)
            && live_frame_blank == $past(pend_frame_blank_r))
        else $error("live copy not loaded at frame-start");

    a_write_pend: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr_en && reg_addr == `SWC_ADDR_FIRST_COL |=>
            pend_first_col_r == $past(reg_wr_data[9:0]))
        else $error("pending first column not written");

    a_read_pend: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == `SWC_ADDR_WIN_ROWS |=>
            reg_rd_valid && reg_rd_data == {7'h00, $past(pend_win_rows_r)})
        else $error("read did not return pending value");

    a_read_resv: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == `SWC_ADDR_ROW_BLANK |=>
            reg_rd_data[15:10] == 6'h00)
        else $error("reserved bits not zero");

    a_read_ver: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == `SWC_ADDR_VERSION |=>
            reg_rd_data == VERSION_ID)
        else $error("version read wrong");

    a_frame_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr_en && !first_dark_row ##1 !first_dark_row |=>
            $stable(live_first_col) && $stable(live_row_blank))
        else $error("write leaked into running frame");

    a_vblank_top: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == `SWC_ADDR_FRAME_BLANK |=>
            reg_rd_data[15] == 1'b0)
        else $error("vertical blank top bit set");

    // The start and blanking fields must move on the same pulse as the
    // window pair, or a frame could mix old and new geometry
    a_load_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
        first_dark_row |=> live_first_col == $past(pend_first_col_r)
            && live_first_row == $past(pend_first_row_r))
        else $error("live start fields not loaded at frame-start");

    a_load_rest: assert property (@(posedge ref_clk) disable iff (!reset_n)
        first_dark_row |=> live_win_rows == $past(pend_win_rows_r)
            && live_row_blank == $past(pend_row_blank_r))
        else $error("live size fields not loaded at frame-start");

    a_live_steady: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !first_dark_row |=> $stable(live_first_col) && $stable(live_first_row)
            && $stable(live_row_blank) && $stable(live_frame_blank))
        else $error("live field changed outside frame-start");

    // Read handshake: valid is a single pulse and data stands until the
    // next read, so a slow host may pick it up late
    a_valid_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en |=> reg_rd_valid)
        else $error("read valid missing after strobe");

    a_valid_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !reg_rd_en |=> !reg_rd_valid)
        else $error("read valid without a strobe");

    a_data_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without a read");

    a_read_col: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == `SWC_ADDR_FIRST_COL |=>
            reg_rd_data == {6'h00, $past(pend_first_col_r)})
        else $error("first column read not from pending");

    // Pending side: only a mapped write may touch a pending copy
    a_write_vblank: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr_en && reg_addr == `SWC_ADDR_FRAME_BLANK |=>
            pend_frame_blank_r == $past(reg_wr_data[14:0]))
        else $error("pending frame blank not written");

    a_pend_steady: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !reg_wr_en |=> $stable(pend_first_col_r) && $stable(pend_win_cols_r)
            && $stable(pend_frame_blank_r) && $stable(pend_row_blank_r))
        else $error("pending copy changed without a write");

    a_write_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr_en && (reg_addr == `SWC_ADDR_VERSION
            || reg_addr > `SWC_ADDR_FRAME_BLANK) |=>
            $stable(pend_first_col_r) && $stable(pend_win_rows_r)
            && $stable(pend_frame_blank_r))
        else $error("write to read-only address landed");

    // Main scenarios worth seeing at least once
    c_write_then_load: cover property (@(posedge ref_clk) disable iff
        (!reset_n) reg_wr_en ##[1:20] first_dark_row);
    c_read_pending: cover property (@(posedge ref_clk) disable iff
        (!reset_n) reg_wr_en ##1 reg_rd_en);
    c_frame_start: cover property (@(posedge ref_clk) disable iff
        (!reset_n) first_dark_row ##[1:50] first_dark_row);
    // A write colliding with the pulse must wait one more frame
    c_write_on_start: cover property (@(posedge ref_clk) disable iff
        (!reset_n) reg_wr_en && first_dark_row);
    c_ignored_write: cover property (@(posedge ref_clk) disable iff
        (!reset_n) reg_wr_en && reg_addr == `SWC_ADDR_VERSION);

endmodule : swc_shadow_regs

// *** testbench/swc_host_model.sv ***
// Host controller model that issues register reads and writes
`timescale 1ns/1ps
module swc_host_model (
    input  wire logic               ref_clk,
    input  wire swc_pkg::swc_data_t rd_data,
    input  wire logic               rd_valid,
    output logic                    wr_en,
    output logic                    rd_en,
    output swc_pkg::swc_addr_t      addr,
    output swc_pkg::swc_data_t      wr_data
);
    // Idle bus shows the inverse of the last value, so stale data never
    // passes for a live request
    initial begin
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        addr    = 8'h00;
        wr_data = 16'h0000;
    end

    // Write: one strobe cycle, then one idle edge before the next request
    task automatic wr(swc_pkg::swc_addr_t a, swc_pkg::swc_data_t d);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        addr    <= ~a;
        wr_data <= ~d;
        @(posedge ref_clk);
    endtask : wr

    // Read: answer is taken at the edge where the valid pulse is sampled
    task automatic rd(swc_pkg::swc_addr_t a, output swc_pkg::swc_data_t d,
                      output logic v);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        addr  <= ~a;
        @(posedge ref_clk);
        d = rd_data;
        v = rd_valid;
    endtask : rd
endmodule : swc_host_model

// *** testbench/tb_swc_shadow_regs.sv ***
// Self-checking bench for the shadowed window configuration bank
`timescale 1ns/1ps
module tb_swc_shadow_regs;
    localparam swc_pkg::swc_data_t VER = 16'h3c3c; // Arbitrary value
    logic               ref_clk, reset_n, wr_en, rd_en, rd_valid, fdr;
    swc_pkg::swc_addr_t addr;
    swc_pkg::swc_data_t wr_data, rd_data;
    logic [9:0]         l_fc, l_wc, l_hb;
    logic [8:0]         l_fr, l_wr;
    logic [14:0]        l_vb;
    int                 err_count = 0;
    int                 n_tests = 0;
    swc_pkg::swc_data_t rst_v[1:6] = '{16'h0001, 16'h0004, 16'h01e0,
                                       16'h02f0, 16'h005e, 16'h002d};
    swc_pkg::swc_data_t msk[1:6] = '{16'h03ff, 16'h01ff, 16'h01ff,
                                     16'h03ff, 16'h03ff, 16'h7fff};
    // Legal values, blanking at its upper limits
    swc_pkg::swc_data_t nv[1:6] = '{16'h02a0, 16'h00c8, 16'h00f0,
                                    16'h0140, 16'h03ff, 16'h0bb8};

    swc_shadow_regs #(.VERSION_ID(VER)) dut_u (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data),
        .reg_rd_valid(rd_valid), .first_dark_row(fdr),
        .live_first_col(l_fc), .live_first_row(l_fr), .live_win_rows(l_wr),
        .live_win_cols(l_wc), .live_row_blank(l_hb), .live_frame_blank(l_vb));
    swc_host_model host (.ref_clk(ref_clk), .rd_data(rd_data),
        .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data));

    // 40 MHz clock
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    function automatic swc_pkg::swc_data_t live(int i);
        case (i)
            1: return {6'h00, l_fc};
            2: return {7'h00, l_fr};
            3: return {7'h00, l_wr};
            4: return {6'h00, l_wc};
            5: return {6'h00, l_hb};
            default: return {1'h0, l_vb};
        endcase
    endfunction : live

    task automatic chk(string s, swc_pkg::swc_data_t e, swc_pkg::swc_data_t g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic rdc(swc_pkg::swc_addr_t a, swc_pkg::swc_data_t e);
        logic               v;
        swc_pkg::swc_data_t d;
        host.rd(a, d, v);
        chk("rd_valid", 16'h0001, {15'h0000, v});
        chk("rd_data", e, d);
    endtask : rdc

    // Frame-start pulse from the row timing, one cycle wide
    task automatic pulse();
        fdr <= 1'b1;
        @(posedge ref_clk);
        fdr <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        fdr     = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rdc(8'hff, VER);
        rdc(8'h07, 16'h0000);
        for (int i = 1; i <= 6; i++) begin
            rdc(i[7:0], rst_v[i]);
            chk("live_reset", rst_v[i], live(i));
        end
        host.wr(8'h00, 16'hffff);
        rdc(8'h00, VER);
        for (int i = 1; i <= 6; i++) host.wr(i[7:0], nv[i] | ~msk[i]);
        for (int i = 1; i <= 6; i++) begin
            rdc(i[7:0], nv[i]);
            chk("live_hold", rst_v[i], live(i));
        end
        // Write landing on the frame-start edge goes live one frame later
        fork
            host.wr(8'h01, 16'h0011);
            pulse();
        join
        for (int i = 1; i <= 6; i++) chk("live_new", nv[i], live(i));
        rdc(8'h01, 16'h0011);
        pulse();
        chk("live_late", 16'h0011, live(1));
        end_of_test();
    end
endmodule : tb_swc_shadow_regs
